// ---- logic/dcs_sideband.v ----
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "dcs_consts.vh"
module dcs_sideband
(
  // clock and reset
  input wire clock,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // supply monitors
  input wire dram_supply_ok,
  input wire core_supply_good,
  // straps
  input wire presence_detect_en_n,
  input wire [1:0] mem_speed_strap,
  input wire [8:0] suspend_well_strap_pins,
  // dram sideband
  output reg dram_reset_n_out,
  output reg [1:0] dram_clk_en,
  output reg phy_isolate,
  output reg use_spd,
  output reg [1:0] speed_sel,
  output reg width_x8,
  output reg [1:0] density_sel,
  output reg one_rank,
  output reg cfg_reserved,
  // management bus, oe low pulls line low
  input wire mgmt_bus_clk_in,
  input wire mgmt_bus_dat_in,
  output wire mgmt_bus_clk_oe_n,
  output wire mgmt_bus_dat_oe_n
);
  reg [31:0] ctrl_r;
  reg [7:0] strap_r;
  reg [5:0] spd_geom_r;
  reg [31:0] smb_cmd_r;
  reg smb_start_r;
  reg [31:0] rdata_nxt;
  reg addr_ok;
  wire smb_busy;
  wire smb_nack;
  wire [7:0] smb_rdata;
  wire apb_wr;
  wire apb_rd;
  wire isolate;
  wire reserved_code;
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;
  assign isolate = !dram_supply_ok || !core_supply_good;
  assign reserved_code = strap_r[`DCS_ST_SPD_BIT] &&
    (strap_r[`DCS_ST_SPEED_LSB + 1] ||
     strap_r[`DCS_ST_DENS_LSB + 1 -: 2] == `DCS_DENS_RSV);
  // ----------------------------------------
  // strap capture at reset release
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (reset)
      strap_r <= 8'h00;
    else if (!strap_r[`DCS_ST_RSV_BIT])
      strap_r <= {1'b1, suspend_well_strap_pins[8], suspend_well_strap_pins[6:5],
        suspend_well_strap_pins[0], mem_speed_strap, presence_detect_en_n};
  end
  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  always @*
  begin
    addr_ok = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `DCS_ADDR_CTRL: rdata_nxt = ctrl_r;
      `DCS_ADDR_STRAP: rdata_nxt = {24'h00_0000, strap_r};
      `DCS_ADDR_STATUS: rdata_nxt = {26'h000_0000, reserved_code, isolate,
        core_supply_good, dram_supply_ok, smb_nack, smb_busy};
      `DCS_ADDR_SMB_CMD: rdata_nxt = smb_cmd_r;
      `DCS_ADDR_SMB_DAT: rdata_nxt = {24'h00_0000, smb_rdata};
      `DCS_ADDR_SPD_GEOM: rdata_nxt = {26'h000_0000, spd_geom_r};
      default: addr_ok = 1'b0;
    endcase
  end
  always @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_r <= `DCS_CTRL_RESET;
      smb_cmd_r <= 32'h0000_0000;
      spd_geom_r <= 6'h00;
      smb_start_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      smb_start_r <= 1'b0;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd)
        prdata <= rdata_nxt;
      if (apb_wr && addr_ok)
      begin
        case (paddr)
          `DCS_ADDR_CTRL: ctrl_r <= {28'h000_0000, pwdata[3:0]};
          `DCS_ADDR_SMB_CMD:
          begin
            // command held while a transfer is in flight
            if (!smb_busy && !smb_start_r)
            begin
              smb_cmd_r <= pwdata;
              smb_start_r <= pwdata[31];
            end
          end
          `DCS_ADDR_SPD_GEOM: spd_geom_r <= pwdata[5:0];
          default: ctrl_r <= ctrl_r;
        endcase
      end
    end
  end
  // ----------------------------------------
  // dram sideband outputs
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (reset)
    begin
      dram_reset_n_out <= 1'b0;
      dram_clk_en <= 2'h0;
      phy_isolate <= 1'b1;
      use_spd <= 1'b0;
      speed_sel <= 2'h0;
      width_x8 <= 1'b0;
      density_sel <= 2'h0;
      one_rank <= 1'b0;
      cfg_reserved <= 1'b0;
    end
    else
    begin
      dram_reset_n_out <= ctrl_r[`DCS_CTRL_RST_BIT];
      phy_isolate <= isolate;
      if (isolate || ctrl_r[`DCS_CTRL_SR_BIT])
        dram_clk_en <= 2'h0;
      else
        dram_clk_en <= ctrl_r[`DCS_CTRL_CKE_LSB + 1 -: 2] &
          {!one_rank, 1'b1};
      use_spd <= !strap_r[`DCS_ST_SPD_BIT];
      speed_sel <= strap_r[`DCS_ST_SPEED_LSB + 1 -: 2];
      cfg_reserved <= reserved_code;
      if (!strap_r[`DCS_ST_SPD_BIT])
      begin
        width_x8 <= spd_geom_r[0];
        density_sel <= spd_geom_r[2:1];
        one_rank <= spd_geom_r[3];
      end
      else
      begin
        width_x8 <= strap_r[`DCS_ST_WIDTH_BIT];
        density_sel <= strap_r[`DCS_ST_DENS_LSB + 1 -: 2];
        one_rank <= strap_r[`DCS_ST_RANK_BIT];
      end
    end
  end
  // ----------------------------------------
  // management bus host
  // ----------------------------------------
  dcs_smb_host u_smb
  (
    .clock(clock),
    .reset(reset),
    .start(smb_start_r),
    .rd(smb_cmd_r[30]),
    .addr(smb_cmd_r[22:16]),
    .offs(smb_cmd_r[15:8]),
    .wdata(smb_cmd_r[7:0]),
    .busy(smb_busy),
    .nack(smb_nack),
    .rdata(smb_rdata),
    .scl_in(mgmt_bus_clk_in),
    .sda_in(mgmt_bus_dat_in),
    .scl_oe_n(mgmt_bus_clk_oe_n),
    .sda_oe_n(mgmt_bus_dat_oe_n)
  );
endmodule

// ---- logic/dcs_consts.vh ----
// Notes on behaviour
// - one shared active-low DRAM reset output
// - supply-ok low isolates PHY, keeps self-refresh
// - core supply-good low isolates PHY
// - presence strap 0 uses SPD, 1 soldered
// - speed strap 00 1066, 01 1333, others reserved
// - width strap 0 x16, 1 x8
// - density strap 00/01/10 = 1/2/4 Gbit
// - rank strap 0 two ranks, 1 one
// - with DIMMs take geometry from SPD data
// - dedicated SMBus host for SPD and sensors
// - SMBus lines only pulled low or released
// - per-rank clock enables control power and self-refresh
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define DCS_ADDR_CTRL 12'h000
`define DCS_ADDR_STRAP 12'h004
`define DCS_ADDR_STATUS 12'h008
`define DCS_ADDR_SMB_CMD 12'h00C
`define DCS_ADDR_SMB_DAT 12'h010
`define DCS_ADDR_SPD_GEOM 12'h014
// ctrl fields
`define DCS_CTRL_RST_BIT 0
`define DCS_CTRL_CKE_LSB 1
`define DCS_CTRL_SR_BIT 3
`define DCS_CTRL_RESET 32'h0000_0000
// strap field positions
`define DCS_ST_SPD_BIT 0
`define DCS_ST_SPEED_LSB 1
`define DCS_ST_WIDTH_BIT 3
`define DCS_ST_DENS_LSB 4
`define DCS_ST_RANK_BIT 6
`define DCS_ST_RSV_BIT 7
// strap encodings
`define DCS_SPEED_1066 2'h0
`define DCS_SPEED_1333 2'h1
`define DCS_WIDTH_X16 1'h0
`define DCS_WIDTH_X8 1'h1
`define DCS_DENS_1G 2'h0
`define DCS_DENS_2G 2'h1
`define DCS_DENS_4G 2'h2
`define DCS_DENS_RSV 2'h3
`define DCS_RANK_TWO 1'h0
`define DCS_RANK_ONE 1'h1
// smbus timing: 10 MHz clock, 100 kHz bus, quarter period 2500 ns
`define DCS_CLK_NS 100
`define DCS_SMB_QTR_NS 2500
`define DCS_SMB_QTR_CYC (`DCS_SMB_QTR_NS / `DCS_CLK_NS)
`endif

// ---- logic/dcs_smb_host.v ----
`timescale 1ns/10ps
`include "dcs_consts.vh"
module dcs_smb_host
(
  // clock and reset
  input wire clock,
  input wire reset,
  // command
  input wire start,
  input wire rd,
  input wire [6:0] addr,
  input wire [7:0] offs,
  input wire [7:0] wdata,
  output reg busy,
  output reg nack,
  output reg [7:0] rdata,
  // open-drain lines, oe low means pulling low
  input wire scl_in,
  input wire sda_in,
  output reg scl_oe_n,
  output reg sda_oe_n
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_BIT = 3'h2;
  localparam [2:0] S_RSTART = 3'h3;
  localparam [2:0] S_STOP = 3'h4;
  reg [2:0] state_r;
  reg [4:0] tick_r;
  reg [1:0] phase_r;
  reg [3:0] bit_r;
  reg [2:0] byte_r;
  reg [8:0] sh_r;
  wire tick;
  wire [31:0] qtr_last;
  wire last_byte;
  wire [2:0] nbytes;
  assign tick = (tick_r == 5'h00);
  assign qtr_last = `DCS_SMB_QTR_CYC - 1;
  assign nbytes = rd ? 3'h4 : 3'h3;
  assign last_byte = (byte_r == nbytes - 3'h1);
  // ----------------------------------------
  // bit-rate divider
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (reset || state_r == S_IDLE)
      tick_r <= 5'h00;
    else if (tick)
      tick_r <= qtr_last[4:0];
    else
      tick_r <= tick_r - 5'h01;
  end
  // ----------------------------------------
  // byte sequencer: addr+w, offs, [data | rstart addr+r, data]
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= S_IDLE;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 3'h0;
      sh_r <= 9'h1FF;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          scl_oe_n <= 1'b1;
          sda_oe_n <= 1'b1;
          if (start)
          begin
            busy <= 1'b1;
            nack <= 1'b0;
            byte_r <= 3'h0;
            phase_r <= 2'h0;
            sh_r <= {addr, 1'b0, 1'b1};
            state_r <= S_START;
          end
        end
        S_START, S_RSTART:
          if (tick)
          begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default:
              begin
                scl_oe_n <= 1'b0;
                bit_r <= 4'h0;
                state_r <= S_BIT;
              end
            endcase
          end
        S_BIT:
          if (tick)
          begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_n <= sh_r[8];
              2'h1: scl_oe_n <= 1'b1;
              2'h2:
                if (scl_in)
                begin
                  sh_r <= {sh_r[7:0], sda_in};
                  if (bit_r == 4'h8 && !(rd && byte_r == 3'h3) && sda_in)
                    nack <= 1'b1;
                end
                else
                  phase_r <= phase_r;
              default:
              begin
                scl_oe_n <= 1'b0;
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8)
                begin
                  bit_r <= 4'h0;
                  byte_r <= byte_r + 3'h1;
                  if (last_byte || nack)
                  begin
                    if (rd && !nack)
                      rdata <= sh_r[8:1];
                    state_r <= S_STOP;
                  end
                  else if (rd && byte_r == 3'h1)
                  begin
                    sh_r <= {addr, 1'b1, 1'b1};
                    state_r <= S_RSTART;
                  end
                  else if (rd && byte_r == 3'h2)
                    sh_r <= 9'h1FF;
                  else
                    sh_r <= {wdata, 1'b1};
                  if (byte_r == 3'h0)
                    sh_r <= {offs, 1'b1};
                end
              end
            endcase
          end
        S_STOP:
          if (tick)
          begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default:
              begin
                busy <= 1'b0;
                state_r <= S_IDLE;
              end
            endcase
          end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- bench/dcs_sideband_props.sv ----
`timescale 1ns/10ps
module dcs_sideband_props
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic dram_supply_ok,
  input wire logic core_supply_good,
  input wire logic [1:0] dram_clk_en,
  input wire logic phy_isolate,
  input wire logic use_spd,
  input wire logic [1:0] speed_sel,
  input wire logic width_x8,
  input wire logic [1:0] density_sel,
  input wire logic one_rank,
  input wire logic cfg_reserved
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_iso_core;
    !core_supply_good |=> phy_isolate;
  endproperty
  a_iso_core: assert property (p_iso_core) else $error("no isolation");
  property p_iso_dram;
    !dram_supply_ok |=> phy_isolate;
  endproperty
  a_iso_dram: assert property (p_iso_dram) else $error("no isolation");
  property p_iso_rel;
    !reset && dram_supply_ok && core_supply_good |=> !phy_isolate;
  endproperty
  a_iso_rel: assert property (p_iso_rel) else $error("isolation held");
  property p_cke_iso;
    phy_isolate && $past(phy_isolate) |-> dram_clk_en == 2'h0;
  endproperty
  a_cke_iso: assert property (p_cke_iso) else $error("cke while isolated");
  property p_cke_rank;
    one_rank && $past(one_rank) |-> !dram_clk_en[1];
  endproperty
  a_cke_rank: assert property (p_cke_rank) else $error("cke on absent rank");
  property p_hold;
    !($past(reset) || $past(reset, 2) || $past(reset, 3)) |->
      $stable({use_spd, speed_sel}) && (use_spd || $stable({width_x8, density_sel, one_rank}));
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_rsv;
    !use_spd |-> cfg_reserved == (speed_sel[1] || density_sel == 2'h3);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
endmodule

// ---- bench/dcs_spd_model.sv ----
`timescale 1ns/10ps
module dcs_spd_model
#(
  parameter [7:0] RD_BYTE = 8'hA5
)
(
  // line levels
  input wire logic scl,
  input wire logic sda,
  // refuse every byte
  input wire logic refuse,
  // low pulls data line low
  output logic sda_oe_n
);
  logic [3:0] k = 4'hF;
  logic [7:0] sh = 8'h00;
  logic rd_mode = 1'h0;
  logic first = 1'h0;
  initial sda_oe_n = 1'h1;
  // start condition restarts framing
  always @(negedge sda)
    if (scl === 1'h1)
    begin
      k = 4'hF;
      rd_mode = 1'h0;
      first = 1'h1;
    end
  always @(posedge scl)
    if (k < 4'h8)
      sh = {sh[6:0], sda};
    else if (k == 4'h8 && rd_mode && sda)
      rd_mode = 1'h0; // host nack ends the read, line released
  // only pulls low or releases
  always @(negedge scl)
  begin
    if (k == 4'h8 && first)
    begin
      rd_mode = sh[0];
      first = 1'h0;
    end
    k = (k == 4'h8) ? 4'h0 : k + 4'h1;
    if (k == 4'h8)
      sda_oe_n = rd_mode | refuse;
    else
      sda_oe_n = ~rd_mode | RD_BYTE[4'h7 - k];
  end
endmodule

// ---- bench/dcs_sideband_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module dcs_sideband_tb;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic dram_ok = 1'h1;
  logic core_ok = 1'h1;
  logic pd = 1'h1;
  logic [1:0] spd = 2'h0;
  logic [8:0] pins = 9'h000;
  logic refuse = 1'h0;
  logic [31:0] rd_q;
  logic err_q;
  logic [7:0] exp;
  logic [7:0] msk;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire [31:0] prdata;
  wire pready, pslverr, dram_reset_n_out, phy_isolate, use_spd, width_x8, one_rank;
  wire cfg_reserved, scl_oe_n, sda_oe_n, spd_oe_n;
  wire [1:0] dram_clk_en, speed_sel, density_sel;
  wire scl_ln = scl_oe_n;
  wire sda_ln = sda_oe_n & spd_oe_n;
  wire [7:0] cfg_obs = {use_spd, speed_sel, width_x8, density_sel, one_rank, cfg_reserved};
  dcs_sideband dut_u
  (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dram_supply_ok(dram_ok), .core_supply_good(core_ok), .presence_detect_en_n(pd),
    .mem_speed_strap(spd), .suspend_well_strap_pins(pins),
    .dram_reset_n_out(dram_reset_n_out), .dram_clk_en(dram_clk_en), .phy_isolate(phy_isolate),
    .use_spd(use_spd), .speed_sel(speed_sel), .width_x8(width_x8), .density_sel(density_sel),
    .one_rank(one_rank), .cfg_reserved(cfg_reserved), .mgmt_bus_clk_in(scl_ln),
    .mgmt_bus_dat_in(sda_ln), .mgmt_bus_clk_oe_n(scl_oe_n), .mgmt_bus_dat_oe_n(sda_oe_n)
  );
  dcs_spd_model spd_u
  (
    .scl(scl_ln), .sda(sda_ln), .refuse(refuse), .sda_oe_n(spd_oe_n)
  );
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails++;
      final_report();
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do
      begin
        @(posedge clock);
      end
      while (pready !== 1'h1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
    end
  endtask
  task smb_wait;
    begin
      repeat (3) @(posedge clock);
      do
      begin
        apb(1'h0, 12'h008, 32'h0);
      end
      while (rd_q[0] !== 1'h0);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    `CHK({dram_reset_n_out, phy_isolate, scl_oe_n, sda_oe_n}, 4'h7)
    repeat (5) @(posedge clock);
    for (int i = 4; i >= 0; i--)
    begin
      reset <= 1'h1;
      pd <= (i != 4);
      spd <= i[1:0];
      pins <= {i[1], 1'h1, i[1:0], 4'hF, i[0]};
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      repeat (4) @(posedge clock);
      exp = {1'h0, i[1:0], i[0], i[1:0], i[1], i[1]};
      msk = 8'hFF;
      if (i == 4)
      begin
        apb(1'h1, 12'h014, 32'hB);
        repeat (2) @(posedge clock);
        exp = 8'h96;
        msk = 8'h9E;
        apb(1'h1, 12'h000, 32'h7);
        repeat (2) @(posedge clock);
        `CHK(dram_clk_en, 2'h1)
      end
      `CHK(cfg_obs & msk, exp)
      apb(1'h0, 12'h004, 32'h0);
      `CHK(rd_q, {24'h0, 1'h1, i[1], i[1:0], i[0], i[1:0], i != 4})
      pd <= ~pd;
      spd <= ~spd;
      pins <= ~pins;
      repeat (4) @(posedge clock);
      `CHK(cfg_obs & msk, exp)
    end
    apb(1'h1, 12'h000, 32'h7);
    repeat (2) @(posedge clock);
    `CHK({dram_reset_n_out, dram_clk_en}, 3'h7)
    apb(1'h1, 12'h000, 32'hF);
    repeat (2) @(posedge clock);
    `CHK(dram_clk_en, 2'h0)
    apb(1'h1, 12'h000, 32'h7);
    dram_ok <= 1'h0;
    repeat (3) @(posedge clock);
    `CHK({phy_isolate, dram_clk_en}, 3'h4)
    apb(1'h0, 12'h008, 32'h0);
    `CHK(rd_q[4:2], 3'h6)
    dram_ok <= 1'h1;
    core_ok <= 1'h0;
    repeat (3) @(posedge clock);
    `CHK({phy_isolate, dram_clk_en}, 3'h4)
    apb(1'h0, 12'h008, 32'h0);
    `CHK(rd_q[4:2], 3'h5)
    core_ok <= 1'h1;
    repeat (3) @(posedge clock);
    `CHK({phy_isolate, dram_clk_en}, 3'h3)
    apb(1'h1, 12'h000, 32'h0);
    repeat (2) @(posedge clock);
    `CHK(dram_reset_n_out, 1'h0)
    apb(1'h1, 12'h018, 32'hFFFF_FFFF);
    `CHK(err_q, 1'h1)
    apb(1'h0, 12'h018, 32'h0);
    `CHK({err_q, rd_q}, 33'h1_0000_0000)
    apb(1'h1, 12'h00C, 32'hC050_1200);
    smb_wait();
    `CHK(rd_q[1:0], 2'h0)
    apb(1'h0, 12'h010, 32'h0);
    `CHK(rd_q[7:0], 8'hA5)
    apb(1'h1, 12'h00C, 32'h8050_1234);
    smb_wait();
    `CHK(rd_q[1:0], 2'h0)
    refuse <= 1'h1;
    apb(1'h1, 12'h00C, 32'h8050_1234);
    smb_wait();
    `CHK(rd_q[1:0], 2'h2)
    `CHK({scl_ln, sda_ln}, 2'h3)
    final_report();
  end
endmodule
bind dcs_sideband dcs_sideband_props props_u
(
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .dram_supply_ok(dram_supply_ok), .core_supply_good(core_supply_good),
  .dram_clk_en(dram_clk_en), .phy_isolate(phy_isolate), .use_spd(use_spd),
  .speed_sel(speed_sel), .width_x8(width_x8), .density_sel(density_sel),
  .one_rank(one_rank), .cfg_reserved(cfg_reserved)
);
